// *** shared/selector_defines.svh ***
// timing counts, gate bit positions and state codes of the source selector
`ifndef SELECTOR_DEFINES_SVH
`define SELECTOR_DEFINES_SVH

`define REF_CLK_MHZ 125
`define TRANS_DELAY_NS 10000
`define TRANS_DELAY_CYC ((`TRANS_DELAY_NS * `REF_CLK_MHZ) / 1000)
`define BLANK_TIME_US 21000
`define BLANK_TIME_CYC (`BLANK_TIME_US * `REF_CLK_MHZ)

`define GATE_ADP_PWR 0
`define GATE_REV_BLK 1
`define GATE_ADP_BLK 2
`define GATE_BAT_DIS 3
`define GATE_DIS_A 4
`define GATE_CHG_A 5
`define GATE_DIS_B 6
`define GATE_CHG_B 7

`define GATES_NONE 8'h00
`define GATES_ADAPTER 8'h03
`define GATES_BAT_A 8'h3C
`define GATES_BAT_B 8'hCC
`define GATES_CHG_A 8'h33
`define GATES_CHG_B 8'hC3

`define CODE_IDLE 3'h0
`define CODE_DIS_A 3'h0
`define CODE_DIS_B 3'h1
`define CODE_AC 3'h2
`define CODE_AIR 3'h3
`define CODE_REL_A 3'h4
`define CODE_REL_B 3'h5
`define CODE_CHG_A 3'h6
`define CODE_CHG_B 3'h7
`define CODE_REL_END 3'h6

`endif

// *** shared/selector_pkg.sv ***
// types shared by the source selector modules
package selector_pkg;

    typedef enum logic [3:0] {
        MODE_IDLE,
        MODE_DIS_A,
        MODE_DIS_B,
        MODE_AC,
        MODE_AIR,
        MODE_REL_A,
        MODE_REL_B,
        MODE_REL_END,
        MODE_CHG_A,
        MODE_CHG_B
    } mode_t;

    typedef enum logic [1:0] {
        BAT_ABSENT,
        BAT_BLANK,
        BAT_NORMAL,
        BAT_UNDER
    } bat_state_t;

    typedef enum logic {
        PH_STEADY,
        PH_BREAK
    } phase_t;

endpackage

// *** hdl/battery_monitor.sv ***
// per-battery presence, insertion blanking and undervoltage latch
`timescale 1ns/1ps
`include "selector_defines.svh"

module battery_monitor
    import selector_pkg::*;
#(
    parameter int BLANK_CYC = `BLANK_TIME_CYC
)
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_above_uv,
    input wire logic i_above_2v,
    input wire logic i_clear_uv,
    output logic o_ok
);

    localparam int BW = $clog2(BLANK_CYC + 1);

    initial
    begin
        if (BLANK_CYC < 1)
        begin
            $error("BLANK_CYC must be at least one");
        end
    end

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] flt;
        bat_state_t st;
        logic dipped;
        logic [BW-1:0] cnt;
        logic ok;
    } mon_t;

    mon_t q_ff;
    mon_t nxt_q;
    logic uv_in;
    logic lo_in;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_q = q_ff;
        nxt_q.s1 = {i_above_2v, i_above_uv};
        nxt_q.s2 = q_ff.s1;
        nxt_q.s3 = q_ff.s2;
        for (int i = 0; i < 2; i++)
        begin
            if (q_ff.s2[i] == q_ff.s3[i])
            begin
                nxt_q.flt[i] = q_ff.s2[i];
            end
        end
        uv_in = ~q_ff.flt[0];
        lo_in = ~q_ff.flt[1];
        unique case (q_ff.st)
            BAT_ABSENT:
            begin
                if (!lo_in)
                begin
                    nxt_q.st = BAT_BLANK;
                    nxt_q.cnt = '0;
                    nxt_q.dipped = 1'b0;
                end
            end
            BAT_BLANK:
            begin
                if (uv_in)
                begin
                    nxt_q.dipped = 1'b1;
                end
                if (lo_in)
                begin
                    nxt_q.st = BAT_ABSENT;
                end
                else if (q_ff.cnt == BW'(BLANK_CYC - 1))
                begin
                    if (!uv_in && !q_ff.dipped)
                    begin
                        nxt_q.st = BAT_NORMAL;
                    end
                    else
                    begin
                        nxt_q.st = BAT_UNDER;
                    end
                end
                else
                begin
                    nxt_q.cnt = q_ff.cnt + BW'(1);
                end
            end
            BAT_NORMAL:
            begin
                if (uv_in && !i_clear_uv)
                begin
                    nxt_q.st = BAT_UNDER;
                end
            end
            BAT_UNDER:
            begin
                if (i_clear_uv)
                begin
                    nxt_q.st = BAT_NORMAL;
                end
                else if (lo_in)
                begin
                    nxt_q.st = BAT_ABSENT;
                end
            end
        endcase
        nxt_q.ok = (nxt_q.st == BAT_NORMAL);
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_nrst)
        begin
            q_ff <= '0;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    assign o_ok = q_ff.ok;

endmodule

// *** hdl/dual_battery_source_selector.sv ***
// mode selection and break-before-make gate sequencing of the source selector
`timescale 1ns/1ps
`include "selector_defines.svh"

module dual_battery_source_selector
    import selector_pkg::*;
#(
    parameter int TRANS_CYC = `TRANS_DELAY_CYC,
    parameter int BLANK_CYC = `BLANK_TIME_CYC
)
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_mains_adapter_sense,
    input wire logic i_aircraft_adapter_sense,
    input wire logic i_relearn_request,
    input wire logic i_charge_request,
    input wire logic i_battery_choice,
    input wire logic i_bat_a_above_uv,
    input wire logic i_bat_a_above_2v,
    input wire logic i_bat_b_above_uv,
    input wire logic i_bat_b_above_2v,
    output logic o_adapter_power_gate,
    output logic o_reverse_block_gate,
    output logic o_adapter_block_gate,
    output logic o_battery_discharge_gate,
    output logic o_discharge_gate_a,
    output logic o_charge_gate_a,
    output logic o_discharge_gate_b,
    output logic o_charge_gate_b,
    output logic [2:0] o_state_code
);

    localparam int CW = $clog2(TRANS_CYC + 1);
    localparam int NIN = 5;
    localparam int IN_AC = 0;
    localparam int IN_AIR = 1;
    localparam int IN_REL = 2;
    localparam int IN_CHG = 3;
    localparam int IN_SEL = 4;

    initial
    begin
        if (TRANS_CYC < 1)
        begin
            $error("TRANS_CYC must be at least one");
        end
    end

    typedef struct packed {
        logic [NIN-1:0] s1;
        logic [NIN-1:0] s2;
        logic [NIN-1:0] s3;
        logic [NIN-1:0] flt;
        phase_t ph;
        mode_t mode;
        mode_t pend;
        logic [CW-1:0] cnt;
        logic term;
        logic [7:0] gates;
        logic [2:0] code;
    } sel_t;

    sel_t q_ff;
    sel_t nxt_q;
    logic ok_a;
    logic ok_b;
    logic clr_a;
    logic clr_b;
    logic ac_in;
    logic air_in;
    logic rel_in;
    logic chg_in;
    logic sel_in;
    logic ok_sel;
    mode_t target;
    logic lost;

    // ------------------------------------------------------------
    // mode decoding
    // ------------------------------------------------------------
    function automatic logic [7:0] gates_of(input mode_t m);
        logic [7:0] g;
        g = `GATES_NONE;
        unique case (m)
            MODE_IDLE: g = `GATES_NONE;
            MODE_DIS_A: g = `GATES_BAT_A;
            MODE_DIS_B: g = `GATES_BAT_B;
            MODE_AC: g = `GATES_ADAPTER;
            MODE_AIR: g = `GATES_ADAPTER;
            MODE_REL_A: g = `GATES_BAT_A;
            MODE_REL_B: g = `GATES_BAT_B;
            MODE_REL_END: g = `GATES_ADAPTER;
            MODE_CHG_A: g = `GATES_CHG_A;
            MODE_CHG_B: g = `GATES_CHG_B;
            default: g = `GATES_NONE;
        endcase
        return g;
    endfunction

    function automatic logic [2:0] code_of(input mode_t m);
        logic [2:0] c;
        c = `CODE_IDLE;
        unique case (m)
            MODE_IDLE: c = `CODE_IDLE;
            MODE_DIS_A: c = `CODE_DIS_A;
            MODE_DIS_B: c = `CODE_DIS_B;
            MODE_AC: c = `CODE_AC;
            MODE_AIR: c = `CODE_AIR;
            MODE_REL_A: c = `CODE_REL_A;
            MODE_REL_B: c = `CODE_REL_B;
            MODE_REL_END: c = `CODE_REL_END;
            MODE_CHG_A: c = `CODE_CHG_A;
            MODE_CHG_B: c = `CODE_CHG_B;
            default: c = `CODE_IDLE;
        endcase
        return c;
    endfunction

    // ------------------------------------------------------------
    // battery monitors
    // ------------------------------------------------------------
    // charge path counts as enabled once its gates are on
    assign clr_a = (q_ff.mode == MODE_CHG_A) && (q_ff.ph == PH_STEADY);
    assign clr_b = (q_ff.mode == MODE_CHG_B) && (q_ff.ph == PH_STEADY);

    battery_monitor #(
        .BLANK_CYC(BLANK_CYC)
    ) u_mon_a (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_above_uv(i_bat_a_above_uv),
        .i_above_2v(i_bat_a_above_2v),
        .i_clear_uv(clr_a),
        .o_ok(ok_a)
    );

    battery_monitor #(
        .BLANK_CYC(BLANK_CYC)
    ) u_mon_b (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_above_uv(i_bat_b_above_uv),
        .i_above_2v(i_bat_b_above_2v),
        .i_clear_uv(clr_b),
        .o_ok(ok_b)
    );

    // ------------------------------------------------------------
    // target source selection
    // ------------------------------------------------------------
    assign ac_in = q_ff.flt[IN_AC] & q_ff.flt[IN_AIR];
    assign air_in = ~q_ff.flt[IN_AC] & q_ff.flt[IN_AIR];
    assign rel_in = q_ff.flt[IN_REL];
    assign chg_in = q_ff.flt[IN_CHG];
    assign sel_in = q_ff.flt[IN_SEL];
    assign ok_sel = sel_in ? ok_b : ok_a;
    // pending battery mode whose battery dropped out of service
    assign lost = (!ok_a && (q_ff.pend == MODE_DIS_A || q_ff.pend == MODE_REL_A))
        || (!ok_b && (q_ff.pend == MODE_DIS_B || q_ff.pend == MODE_REL_B));

    always_comb
    begin
        target = MODE_IDLE;
        if (air_in)
        begin
            target = MODE_AIR;
        end
        else if (ac_in)
        begin
            if (rel_in && (q_ff.term || (q_ff.mode == MODE_REL_A && !ok_a)
                || (q_ff.mode == MODE_REL_B && !ok_b)))
            begin
                target = MODE_REL_END;
            end
            else if (rel_in && ok_sel)
            begin
                target = sel_in ? MODE_REL_B : MODE_REL_A;
            end
            else if (chg_in && !rel_in)
            begin
                target = sel_in ? MODE_CHG_B : MODE_CHG_A;
            end
            else
            begin
                target = MODE_AC;
            end
        end
        else if (ok_a && (!sel_in || !ok_b))
        begin
            target = MODE_DIS_A;
        end
        else if (ok_b)
        begin
            target = MODE_DIS_B;
        end
        else
        begin
            target = MODE_IDLE;
        end
    end

    // ------------------------------------------------------------
    // synchronisers and break-before-make sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_q = q_ff;
        nxt_q.s1 = {i_battery_choice, i_charge_request, i_relearn_request,
                    i_aircraft_adapter_sense, i_mains_adapter_sense};
        nxt_q.s2 = q_ff.s1;
        nxt_q.s3 = q_ff.s2;
        for (int i = 0; i < NIN; i++)
        begin
            if (q_ff.s2[i] == q_ff.s3[i])
            begin
                nxt_q.flt[i] = q_ff.s2[i];
            end
        end
        // relearn end flag: set beats the clear
        if ((q_ff.mode == MODE_REL_A && !ok_a) || (q_ff.mode == MODE_REL_B && !ok_b))
        begin
            nxt_q.term = 1'b1;
        end
        else if (!rel_in || !ac_in)
        begin
            nxt_q.term = 1'b0;
        end
        unique case (q_ff.ph)
            PH_STEADY:
            begin
                if (target != q_ff.mode)
                begin
                    nxt_q.ph = PH_BREAK;
                    nxt_q.pend = target;
                    nxt_q.cnt = '0;
                    // drop only gates absent from the incoming set
                    nxt_q.gates = q_ff.gates & gates_of(target);
                end
            end
            PH_BREAK:
            begin
                // a battery lost mid-break must not be turned on: restart the break
                if (lost)
                begin
                    nxt_q.pend = target;
                    nxt_q.cnt = '0;
                    nxt_q.gates = q_ff.gates & gates_of(target);
                end
                else if (q_ff.cnt == CW'(TRANS_CYC - 1))
                begin
                    nxt_q.ph = PH_STEADY;
                    nxt_q.mode = q_ff.pend;
                    nxt_q.gates = gates_of(q_ff.pend);
                    nxt_q.code = code_of(q_ff.pend);
                end
                else
                begin
                    nxt_q.cnt = q_ff.cnt + CW'(1);
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_nrst)
        begin
            q_ff <= '0;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_adapter_power_gate = q_ff.gates[`GATE_ADP_PWR];
    assign o_reverse_block_gate = q_ff.gates[`GATE_REV_BLK];
    assign o_adapter_block_gate = q_ff.gates[`GATE_ADP_BLK];
    assign o_battery_discharge_gate = q_ff.gates[`GATE_BAT_DIS];
    assign o_discharge_gate_a = q_ff.gates[`GATE_DIS_A];
    assign o_charge_gate_a = q_ff.gates[`GATE_CHG_A];
    assign o_discharge_gate_b = q_ff.gates[`GATE_DIS_B];
    assign o_charge_gate_b = q_ff.gates[`GATE_CHG_B];
    assign o_state_code = q_ff.code;

endmodule

// *** tb/source_env_model.sv ***
// behavioural model of the adapter and battery comparators
`timescale 1ns/1ps
module source_env_model
(
    input wire logic [1:0] i_adapter_kind,
    input wire logic [1:0] i_level_a,
    input wire logic [1:0] i_level_b,
    output logic o_mains_sense,
    output logic o_aircraft_sense,
    output logic o_a_above_uv,
    output logic o_a_above_2v,
    output logic o_b_above_uv,
    output logic o_b_above_2v
);
    // kind: 0 absent, 1 airline, 2 ac; level: 0 removed, 1 low, 2 above threshold
    assign o_mains_sense = (i_adapter_kind == 2'h2);
    assign o_aircraft_sense = (i_adapter_kind != 2'h0);
    assign o_a_above_2v = (i_level_a != 2'h0);
    assign o_a_above_uv = (i_level_a == 2'h2);
    assign o_b_above_2v = (i_level_b != 2'h0);
    assign o_b_above_uv = (i_level_b == 2'h2);
endmodule

// *** tb/source_selector_asserts.sv ***
// assertion checker of the source selector outputs
`timescale 1ns/1ps
module source_selector_checker
#(
    parameter int TRANS_CYC = 8,
    parameter int BLANK_CYC = 50
)
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_mains_adapter_sense,
    input wire logic i_aircraft_adapter_sense,
    input wire logic i_relearn_request,
    input wire logic i_charge_request,
    input wire logic i_battery_choice,
    input wire logic i_bat_a_above_uv,
    input wire logic i_bat_a_above_2v,
    input wire logic i_bat_b_above_uv,
    input wire logic i_bat_b_above_2v,
    input wire logic o_adapter_power_gate,
    input wire logic o_reverse_block_gate,
    input wire logic o_adapter_block_gate,
    input wire logic o_battery_discharge_gate,
    input wire logic o_discharge_gate_a,
    input wire logic o_charge_gate_a,
    input wire logic o_discharge_gate_b,
    input wire logic o_charge_gate_b,
    input wire logic [2:0] o_state_code
);
    logic [7:0] g_q;
    int unsigned since_fall;
    int unsigned air_cnt;
    wire [7:0] g = {o_charge_gate_b, o_discharge_gate_b, o_charge_gate_a, o_discharge_gate_a,
        o_battery_discharge_gate, o_adapter_block_gate, o_reverse_block_gate,
        o_adapter_power_gate};
    wire fell = |(g_q & ~g);
    wire rose = |(~g_q & g);
    wire air_only = i_aircraft_adapter_sense && !i_mains_adapter_sense;
    // cycles since a gate last dropped, and cycles of steady airline input
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_nrst)
        begin
            g_q <= 8'h00;
            since_fall <= TRANS_CYC;
            air_cnt <= 0;
        end
        else
        begin
            g_q <= g;
            if (fell)
                since_fall <= 1;
            else if (since_fall < TRANS_CYC)
                since_fall <= since_fall + 1;
            if (!air_only)
                air_cnt <= 0;
            else if (air_cnt < 2 * TRANS_CYC + 8)
                air_cnt <= air_cnt + 1;
        end
    end
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);
    airline_gates_a: assert property (o_state_code == 3'h3 |->
        (g & 8'hFC) == 8'h00 && (fell || since_fall != TRANS_CYC || g == 8'h03))
        else $error("airline code with wrong gates");
    airline_follow_a: assert property (air_cnt == 2 * TRANS_CYC + 8 |-> o_state_code == 3'h3)
        else $error("airline input not followed");
    relearn_path_a: assert property (o_state_code[2:1] == 2'h2 |->
        !o_adapter_power_gate && (fell || since_fall != TRANS_CYC
        || (o_battery_discharge_gate && (o_discharge_gate_a != o_discharge_gate_b))))
        else $error("relearn code with wrong gates");
    charge_path_a: assert property (o_state_code == 3'h7 |->
        (g & 8'h3C) == 8'h00 && (fell || since_fall != TRANS_CYC || g == 8'hC3))
        else $error("charge b code with wrong gates");
    no_cross_a: assert property (!(o_discharge_gate_a && o_discharge_gate_b)
        && !(o_adapter_power_gate && o_battery_discharge_gate))
        else $error("two sources joined");
    bbm_gap_a: assert property (rose |-> since_fall == TRANS_CYC)
        else $error("turn-on not one delay after turn-off");
    code_turnon_a: assert property ($changed(o_state_code) |-> since_fall == TRANS_CYC)
        else $error("code changed outside turn-on");
    single_step_a: assert property (fell |-> !rose ##1 !rose)
        else $error("turn-off and turn-on overlap");
endmodule

bind dual_battery_source_selector source_selector_checker #(.TRANS_CYC(TRANS_CYC),
    .BLANK_CYC(BLANK_CYC)) checker_inst (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_mains_adapter_sense(i_mains_adapter_sense),
    .i_aircraft_adapter_sense(i_aircraft_adapter_sense),
    .i_relearn_request(i_relearn_request), .i_charge_request(i_charge_request),
    .i_battery_choice(i_battery_choice), .i_bat_a_above_uv(i_bat_a_above_uv),
    .i_bat_a_above_2v(i_bat_a_above_2v), .i_bat_b_above_uv(i_bat_b_above_uv),
    .i_bat_b_above_2v(i_bat_b_above_2v), .o_adapter_power_gate(o_adapter_power_gate),
    .o_reverse_block_gate(o_reverse_block_gate), .o_adapter_block_gate(o_adapter_block_gate),
    .o_battery_discharge_gate(o_battery_discharge_gate),
    .o_discharge_gate_a(o_discharge_gate_a), .o_charge_gate_a(o_charge_gate_a),
    .o_discharge_gate_b(o_discharge_gate_b), .o_charge_gate_b(o_charge_gate_b),
    .o_state_code(o_state_code));

// *** tb/testbench.sv ***
// self-checking bench of the source selector
`timescale 1ns/1ps
`include "selector_defines.svh"
`define CHECK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp); \
        end \
    end
module testbench
    import selector_pkg::*;
;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [1:0] lvl_a = 2'h0;
    logic [1:0] lvl_b = 2'h0;
    logic relearn = 1'b0;
    logic charge = 1'b0;
    logic choice = 1'b0;
    int mismatches = 0;
    int n_compared = 0;
    logic mains, air, a_uv, a_2v, b_uv, b_2v;
    wire [7:0] gates;
    logic [2:0] code;

    always #4 ref_clk = ~ref_clk;

    source_env_model source_env_model_inst (.i_adapter_kind(kind), .i_level_a(lvl_a),
        .i_level_b(lvl_b), .o_mains_sense(mains), .o_aircraft_sense(air),
        .o_a_above_uv(a_uv), .o_a_above_2v(a_2v), .o_b_above_uv(b_uv), .o_b_above_2v(b_2v));

    // short counts keep the run brief
    dual_battery_source_selector #(.TRANS_CYC(8), .BLANK_CYC(50)) dual_battery_source_selector_inst (
        .i_ref_clk(ref_clk), .i_nrst(nrst), .i_mains_adapter_sense(mains),
        .i_aircraft_adapter_sense(air), .i_relearn_request(relearn),
        .i_charge_request(charge), .i_battery_choice(choice), .i_bat_a_above_uv(a_uv),
        .i_bat_a_above_2v(a_2v), .i_bat_b_above_uv(b_uv), .i_bat_b_above_2v(b_2v),
        .o_adapter_power_gate(gates[`GATE_ADP_PWR]), .o_reverse_block_gate(gates[`GATE_REV_BLK]),
        .o_adapter_block_gate(gates[`GATE_ADP_BLK]),
        .o_battery_discharge_gate(gates[`GATE_BAT_DIS]),
        .o_discharge_gate_a(gates[`GATE_DIS_A]), .o_charge_gate_a(gates[`GATE_CHG_A]),
        .o_discharge_gate_b(gates[`GATE_DIS_B]), .o_charge_gate_b(gates[`GATE_CHG_B]),
        .o_state_code(code));

    // ---------------------------------------------
    // host and source steps
    // ---------------------------------------------
    // pins change once per step and then stay put for n cycles
    task automatic step(input logic [1:0] k, input logic [1:0] a, input logic [1:0] b,
        input logic rl, input logic ch, input logic cs, input int n,
        input logic [7:0] eg, input logic [2:0] ec, input string name);
        @(negedge ref_clk);
        kind = k;
        lvl_a = a;
        lvl_b = b;
        relearn = rl;
        charge = ch;
        choice = cs;
        repeat (n) @(negedge ref_clk);
        `CHECK(gates, eg)
        `CHECK(code, ec)
        $display("test %s done", name);
    endtask

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(negedge ref_clk);
        nrst = 1'b1;
        step(0, 0, 0, 0, 0, 0, 4, `GATES_NONE, `CODE_IDLE, "reset idle");
        step(0, 2, 0, 0, 0, 0, 30, `GATES_NONE, `CODE_IDLE, "blanking");
        step(0, 2, 0, 0, 0, 0, 50, `GATES_BAT_A, `CODE_DIS_A, "battery a");
        step(0, 2, 2, 0, 0, 1, 80, `GATES_BAT_B, `CODE_DIS_B, "swap");
        step(2, 2, 2, 0, 0, 1, 40, `GATES_ADAPTER, `CODE_AC, "ac");
        step(2, 2, 2, 0, 1, 0, 40, `GATES_CHG_A, `CODE_CHG_A, "charge a");
        step(2, 2, 2, 1, 1, 1, 40, `GATES_BAT_B, `CODE_REL_B, "relearn");
        step(2, 2, 1, 1, 1, 1, 40, `GATES_ADAPTER, `CODE_REL_END, "relearn end");
        step(2, 2, 1, 0, 0, 1, 40, `GATES_ADAPTER, `CODE_AC, "release");
        step(2, 2, 1, 1, 0, 1, 40, `GATES_ADAPTER, `CODE_AC, "refused");
        step(1, 2, 1, 1, 1, 1, 40, `GATES_ADAPTER, `CODE_AIR, "airline");
        step(2, 2, 2, 0, 1, 1, 40, `GATES_CHG_B, `CODE_CHG_B, "charge b");
        step(0, 2, 2, 0, 0, 1, 40, `GATES_BAT_B, `CODE_DIS_B, "cleared");
        step(0, 2, 2, 1, 0, 1, 40, `GATES_BAT_B, `CODE_DIS_B, "no adapter");
        step(1, 2, 2, 1, 0, 1, 40, `GATES_ADAPTER, `CODE_AIR, "seen airline");
        step(2, 2, 2, 1, 0, 1, 40, `GATES_BAT_B, `CODE_REL_B, "then ac");
        step(0, 2, 1, 0, 0, 1, 40, `GATES_BAT_A, `CODE_DIS_A, "b low");
        step(0, 0, 1, 0, 0, 1, 40, `GATES_NONE, `CODE_IDLE, "none usable");
        step(0, 1, 1, 0, 0, 0, 80, `GATES_NONE, `CODE_IDLE, "low insert");
        print_verdict();
    end

    initial
    begin
        repeat (3000) @(posedge ref_clk);
        mismatches++;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        print_verdict();
    end
endmodule
